// ### core/xes_entry_sequencer.sv
// exception entry sequencer: arbitration, link save, mode and vector forcing
// How it works
// - reset entry: save word to supervisor link, supervisor mode, both disables, vector 0
// - undefined trap: supervisor link, supervisor mode, normal disable, vector 4
// - software trap: supervisor link, supervisor mode, normal disable, vector 8
// - aborts: supervisor link and mode, normal disable; data 10h, prefetch 0Ch
// - address fault: store becomes load, completes, supervisor entry, vector 14h
// - normal interrupt: interrupt-bank link, interrupt mode, normal disable, vector 18h
// - fast interrupt: fast-bank link, fast mode, both disables, vector 1Ch
// - link value chosen so documented return offsets resume correctly
// - offer coprocessor decodes, stall while busy, undefined trap if none accepts
// - hold input high forces no-ops; falling edge runs reset entry
// - fixed priority: reset, address/data fault, fast, normal, prefetch, undef/trap
// - memory fault input on a data cycle ignored when transfer address is illegal
// - fault plus enabled fast interrupt: fault entry then fast entry at once
// - fast interrupt latency bounded by 25.5 cycles worst case
// - minimum interrupt recognition lag is 3.5 cycles
// - active-low interrupt requests pass a synchroniser first
// - interrupts sampled at instruction end, taken only if not disabled
// - address fault when any top six address bits set, first word only
// - memory fault sampled at end of first bus phase; internal cycles ignored
`timescale 1ns/100ps
module xes_entry_sequencer
	import xes_pkg::*;
(
	// clock and reset
	input  wire logic              clk,
	input  wire logic              rst_n,
	// external pins
	input  wire logic              init_hold_input,
	input  wire logic              fast_interrupt_request_n,
	input  wire logic              normal_interrupt_request_n,
	input  wire logic              memory_fault_input,
	// bus cycle timing from the core
	input  wire logic              busPhase1End,
	input  wire logic              busInternal,
	input  wire logic              busIsFetch,
	input  wire logic              pipeFlush,
	// retiring instruction
	input  wire xes_pkg::xes_core_t core,
	input  wire logic [PSW_W-1:0]  pc_status_word,
	// coprocessor handshake
	input  wire xes_pkg::xes_cop_t cop,
	output logic                   copOffer,
	// control back to the core
	output logic                   execNop,
	output logic                   stallCore,
	output logic                   storeToLoad,
	output logic                   suppressWrite,
	// entry result
	output logic                   entryValid,
	output xes_pkg::xes_entry_t    entry,
	output logic [PSW_W-1:0]       link_register,
	output logic [PSW_W-1:0]       processor_status_word,
	output logic                   mode_select_upper,
	output logic                   mode_select_lower
);
	import xes_pkg::*;

	// ---------------------------------------------------------------
	// synchronisers
	// ---------------------------------------------------------------
	logic fiqSyncN;
	logic irqSyncN;
	logic holdSync;
	logic faultSync;

	xes_sync #(.RST_VAL(1'b1)) uFiqSync (.clk(clk), .rst_n(rst_n),
		.asyncIn(fast_interrupt_request_n), .syncOut(fiqSyncN));
	xes_sync #(.RST_VAL(1'b1)) uIrqSync (.clk(clk), .rst_n(rst_n),
		.asyncIn(normal_interrupt_request_n), .syncOut(irqSyncN));
	xes_sync #(.RST_VAL(1'b1)) uHoldSync (.clk(clk), .rst_n(rst_n),
		.asyncIn(init_hold_input), .syncOut(holdSync));
	xes_sync #(.RST_VAL(1'b0)) uFaultSync (.clk(clk), .rst_n(rst_n),
		.asyncIn(memory_fault_input), .syncOut(faultSync));

	// ---------------------------------------------------------------
	// status word and pending state
	// ---------------------------------------------------------------
	logic [PSW_W-1:0] psw_r;
	logic             holdPrev_r;
	logic             resetPend_r;
	logic             dataFault_r;
	logic             fetchFault_r;
	logic             chainFiq_r;
	logic [1:0]       entryCnt_r;

	wire addrIllegal = core.dataXfer && ((core.xferAddr & ADDR_ERR_MSK) != '0);
	wire fiqEn       = !psw_r[BIT_FIQ_DIS];
	wire irqEn       = !psw_r[BIT_IRQ_DIS];
	wire fiqReq      = !fiqSyncN && fiqEn;
	wire irqReq      = !irqSyncN && irqEn;
	wire busyEntry   = entryCnt_r != '0;

	assign execNop               = holdSync;
	assign storeToLoad           = addrIllegal && core.isStore;
	assign suppressWrite         = dataFault_r;
	assign processor_status_word = psw_r;
	assign mode_select_upper     = psw_r[MODE_HI];
	assign mode_select_lower     = psw_r[0];

	// ---------------------------------------------------------------
	// coprocessor hand-off
	// ---------------------------------------------------------------
	assign copOffer  = core.insEnd && core.copInstr && !holdSync;
	assign stallCore = holdSync || busyEntry || (copOffer && cop.accept && cop.busy);
	wire copDone     = copOffer && cop.accept && !cop.busy;
	wire undefTrap   = copOffer && !cop.accept;

	// ---------------------------------------------------------------
	// memory fault capture
	// ---------------------------------------------------------------
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			dataFault_r  <= 1'b0;
			fetchFault_r <= 1'b0;
		end else begin
			// clears first so that a new fault in the same cycle wins
			if (pipeFlush)
				fetchFault_r <= 1'b0;
			if (entryValid && entry.vector == VEC_DABT)
				dataFault_r <= 1'b0;
			else if (entryValid && entry.vector == VEC_PABT)
				fetchFault_r <= 1'b0;
			if (busPhase1End && !busInternal && faultSync) begin
				if (busIsFetch)
					fetchFault_r <= 1'b1;
				else if (!addrIllegal)
					dataFault_r <= 1'b1;
			end
		end
	end

	// ---------------------------------------------------------------
	// reset hold
	// ---------------------------------------------------------------
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			holdPrev_r  <= 1'b0;
			resetPend_r <= 1'b1;
		end else begin
			holdPrev_r <= holdSync;
			if (holdPrev_r && !holdSync)
				resetPend_r <= 1'b1;
			else if (entryValid && entry.vector == VEC_RESET && !holdSync)
				resetPend_r <= 1'b0;
		end
	end

	// ---------------------------------------------------------------
	// arbitration
	// ---------------------------------------------------------------
	xes_kind_t kind;
	logic      boundary;

	always_comb begin
		boundary = (core.insEnd && !(copOffer && cop.accept && cop.busy)) || chainFiq_r;
		kind     = XES_NONE;
		if (holdSync || busyEntry)
			kind = XES_NONE;
		else if (resetPend_r)
			kind = XES_RESET;
		else if (chainFiq_r)
			kind = XES_FIQ;
		else if (!boundary)
			kind = XES_NONE;
		else if (addrIllegal)
			kind = XES_ADDR;
		else if (dataFault_r)
			kind = XES_DABT;
		else if (fiqReq)
			kind = XES_FIQ;
		else if (irqReq)
			kind = XES_IRQ;
		else if (core.prefetchBad || fetchFault_r)
			kind = XES_PABT;
		else if (undefTrap)
			kind = XES_UNDEF;
		else if (core.swTrap && !copDone)
			kind = XES_SWT;
	end

	// ---------------------------------------------------------------
	// entry decode
	// ---------------------------------------------------------------
	xes_entry_t nxtEntry;
	logic [25:0] retAdj;

	always_comb begin
		nxtEntry = '{vector: VEC_RESET, mode: MODE_SVC, setFiqDis: 1'b0,
			setIrqDis: 1'b1, bank: MODE_SVC};
		retAdj   = '0;
		case (kind)
			XES_RESET: begin
				nxtEntry.setFiqDis = 1'b1;
			end
			XES_UNDEF: nxtEntry.vector = VEC_UNDEF;
			XES_SWT:   nxtEntry.vector = VEC_SWT;
			XES_PABT: begin
				nxtEntry.vector = VEC_PABT;
				retAdj          = RET_OFF_4;
			end
			XES_DABT: begin
				nxtEntry.vector = VEC_DABT;
				retAdj          = RET_OFF_8;
			end
			XES_ADDR: begin
				nxtEntry.vector = VEC_ADDR;
				retAdj          = RET_OFF_4;
			end
			XES_IRQ: begin
				nxtEntry.vector = VEC_IRQ;
				nxtEntry.mode   = MODE_IRQ;
				nxtEntry.bank   = MODE_IRQ;
				retAdj          = RET_OFF_4;
			end
			XES_FIQ: begin
				nxtEntry.vector    = VEC_FIQ;
				nxtEntry.mode      = MODE_FIQ;
				nxtEntry.bank      = MODE_FIQ;
				nxtEntry.setFiqDis = 1'b1;
				retAdj             = RET_OFF_4;
			end
			default: nxtEntry = '{vector: VEC_RESET, mode: MODE_SVC, setFiqDis: 1'b0,
				setIrqDis: 1'b1, bank: MODE_SVC};
		endcase
	end

	// saved pc field points so that return offsets resume correctly
	wire [25:0] curPc = {pc_status_word[PC_HI:PC_LO], 2'b00};
	wire [25:0] linkPc = curPc + retAdj;

	// ---------------------------------------------------------------
	// entry sequencing and status update
	// ---------------------------------------------------------------
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			psw_r         <= '0;
			psw_r[1:0]    <= MODE_SVC;
			psw_r[BIT_IRQ_DIS] <= 1'b1;
			psw_r[BIT_FIQ_DIS] <= 1'b1;
			entryValid    <= 1'b0;
			entry         <= '0;
			link_register <= '0;
			entryCnt_r    <= '0;
			chainFiq_r    <= 1'b0;
		end else begin
			entryValid <= 1'b0;
			if (busyEntry)
				entryCnt_r <= entryCnt_r - 2'h1;
			if (kind != XES_NONE) begin
				entryValid    <= 1'b1;
				entry         <= nxtEntry;
				link_register <= {pc_status_word[31:26], linkPc[PC_HI:PC_LO],
					pc_status_word[1:0]};
				psw_r[1:0]    <= nxtEntry.mode;
				psw_r[PC_HI:PC_LO] <= nxtEntry.vector[PC_HI:PC_LO];
				psw_r[BIT_IRQ_DIS] <= 1'b1;
				if (nxtEntry.setFiqDis)
					psw_r[BIT_FIQ_DIS] <= 1'b1;
				entryCnt_r    <= 2'(ENTRY_CYCLES - 1);
				chainFiq_r    <= (kind == XES_ADDR || kind == XES_DABT) && fiqReq;
			end else if (!busyEntry) begin
				psw_r <= pc_status_word;
				chainFiq_r <= 1'b0;
			end
		end
	end

	// worst case: sync + longest instruction + fault entry + fast entry, rounded down = MAX_FIQ_LAT
	// fast request held by requester until mode shows fast mode; only chainFiq_r latches it, across a fault entry
endmodule

// ### core/xes_pkg.sv
// package for the exception entry sequencer: vectors, modes, flags, timing
package xes_pkg;

	// ---------------------------------------------------------------
	// processor status word layout (26-bit pc in bits 25:2)
	// ---------------------------------------------------------------
	localparam int          PSW_W        = 32;
	localparam int          BIT_IRQ_DIS  = 27;
	localparam int          BIT_FIQ_DIS  = 26;
	localparam int          MODE_HI      = 1;
	localparam int          PC_LO        = 2;
	localparam int          PC_HI        = 25;
	localparam logic [31:0] ADDR_ERR_MSK = 32'hFC00_0000;

	// ---------------------------------------------------------------
	// mode encodings and vectors
	// ---------------------------------------------------------------
	localparam logic [1:0]  MODE_USR = 2'h0;
	localparam logic [1:0]  MODE_FIQ = 2'h1;
	localparam logic [1:0]  MODE_IRQ = 2'h2;
	localparam logic [1:0]  MODE_SVC = 2'h3;

	localparam logic [25:0] VEC_RESET = 26'h000_0000;
	localparam logic [25:0] VEC_UNDEF = 26'h000_0004;
	localparam logic [25:0] VEC_SWT   = 26'h000_0008;
	localparam logic [25:0] VEC_PABT  = 26'h000_000C;
	localparam logic [25:0] VEC_DABT  = 26'h000_0010;
	localparam logic [25:0] VEC_ADDR  = 26'h000_0014;
	localparam logic [25:0] VEC_IRQ   = 26'h000_0018;
	localparam logic [25:0] VEC_FIQ   = 26'h000_001C;

	// return offsets the saved link value is built for
	localparam logic [25:0] RET_OFF_4 = 26'h000_0004;
	localparam logic [25:0] RET_OFF_8 = 26'h000_0008;

	// ---------------------------------------------------------------
	// timing: clock 100 MHz
	// ---------------------------------------------------------------
	localparam real CLK_NS          = 10.0;
	localparam real SYNC_MAX_CYC    = 2.5;
	localparam real LONGEST_INS_CYC = 18.0;
	localparam real FAULT_ENTRY_CYC = 3.0;
	localparam real FAST_ENTRY_CYC  = 2.0;
	localparam real MIN_LAG_CYC     = 3.5;
	// entry takes fast-entry cycles, rounded down, at least one
	localparam int  ENTRY_CYCLES    = (FAST_ENTRY_CYC < 1.0) ? 1 : int'($floor(FAST_ENTRY_CYC));
	localparam int  MAX_FIQ_LAT     =
		int'($floor(SYNC_MAX_CYC + LONGEST_INS_CYC + FAULT_ENTRY_CYC + FAST_ENTRY_CYC));
	localparam int  MIN_LAG         = int'($ceil(MIN_LAG_CYC));

	// ---------------------------------------------------------------
	// exception kinds, highest priority first
	// ---------------------------------------------------------------
	typedef enum logic [3:0] {
		XES_NONE, XES_RESET, XES_ADDR, XES_DABT, XES_FIQ,
		XES_IRQ, XES_PABT, XES_UNDEF, XES_SWT
	} xes_kind_t;

	typedef struct packed {
		logic [25:0] vector;
		logic [1:0]  mode;
		logic        setFiqDis;
		logic        setIrqDis;
		logic [1:0]  bank;      // link register bank
	} xes_entry_t;

	// state that the core reports at an instruction boundary
	typedef struct packed {
		logic        insEnd;       // instruction retires this cycle
		logic        swTrap;       // retiring instruction is a software trap
		logic        copInstr;     // coprocessor or undefined decode
		logic        prefetchBad;  // retiring instruction carried a fetch fault
		logic        dataXfer;     // retiring instruction moved data
		logic        isStore;
		logic [31:0] xferAddr;     // first word address
	} xes_core_t;

	// coprocessor handshake
	typedef struct packed {
		logic accept;
		logic busy;
	} xes_cop_t;

endpackage

// ### core/xes_sync.sv
// two-stage synchroniser for an asynchronous level
`timescale 1ns/100ps
module xes_sync #(
	parameter logic RST_VAL = 1'b1
) (
	// clock and reset
	input  wire logic clk,
	input  wire logic rst_n,
	// level in and out
	input  wire logic asyncIn,
	output logic      syncOut
);
	logic stage1_r;

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			stage1_r <= RST_VAL;
			syncOut  <= RST_VAL;
		end else begin
			stage1_r <= asyncIn;
			syncOut  <= stage1_r;
		end
	end
endmodule

// ### sim/xes_entry_sequencer_assertions.sv
// port assertions for the exception entry sequencer
`timescale 1ns/100ps
module xes_entry_sequencer_chk
	import xes_pkg::*;
(
	// clock and reset
	input logic                clk,
	input logic                rst_n,
	// watched ports
	input xes_pkg::xes_core_t  core,
	input logic [PSW_W-1:0]    pc_status_word,
	input xes_pkg::xes_cop_t   cop,
	input logic                execNop,
	input logic                stallCore,
	input logic                storeToLoad,
	input logic                entryValid,
	input xes_pkg::xes_entry_t entry,
	input logic [PSW_W-1:0]    link_register
);
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_n);
	// ----------------
	// entry checks
	// ----------------
	one_entry_a: assert property (entryValid |=> !entryValid)
		else $error("entry pulse too long");
	fiq_entry_a: assert property (entryValid && entry.vector == VEC_FIQ |->
		entry.mode == MODE_FIQ && entry.setFiqDis && entry.setIrqDis) else $error("bad fast entry");
	irq_entry_a: assert property (entryValid && entry.vector == VEC_IRQ |->
		entry.mode == MODE_IRQ && entry.setIrqDis && !entry.setFiqDis) else $error("bad irq entry");
	svc_entry_a: assert property (entryValid && entry.vector < VEC_IRQ |->
		entry.mode == MODE_SVC && entry.setIrqDis && entry.setFiqDis == (entry.vector == VEC_RESET))
		else $error("bad supervisor entry");
	dabt_link_a: assert property (entryValid && entry.vector == VEC_DABT |->
		link_register[PC_HI:PC_LO] == $past(pc_status_word[PC_HI:PC_LO]) + 24'h2)
		else $error("bad data fault link");
	nop_quiet_a: assert property (execNop |-> stallCore ##1 !entryValid)
		else $error("entry while held");
	cop_wait_a: assert property (cop.accept && cop.busy |-> stallCore ##1 !entryValid)
		else $error("no stall on busy coprocessor");
	addr_store_a: assert property (core.insEnd && core.dataXfer && core.isStore && !execNop &&
		(core.xferAddr & ADDR_ERR_MSK) != 32'h0 |-> storeToLoad) else $error("store not turned");
endmodule
bind xes_entry_sequencer xes_entry_sequencer_chk xes_entry_sequencer_chk_i (.clk, .rst_n,
	.core, .pc_status_word, .cop, .execNop, .stallCore, .storeToLoad, .entryValid, .entry,
	.link_register);

// ### sim/xes_entry_sequencer_tb_top.sv
// bench for the exception entry sequencer: instruction and pin tests
`timescale 1ns/100ps
module xes_entry_sequencer_tb_top;
	import xes_pkg::*;
	// ----------------
	// wiring
	// ----------------
	logic             clk = 1'b0, rst_n = 1'b0, hold = 1'b0, irqN = 1'b1, fault = 1'b0;
	logic             ph1 = 1'b0, intl = 1'b0, copPresent = 1'b1, fiqRaise = 1'b0;
	logic [PSW_W-1:0] pcw = 32'h0000_1000;
	logic [31:0]      adr [3] = '{32'h0400_0000, 32'h03FF_FFFC, 32'h8000_0000};
	xes_core_t        core = '0;
	xes_cop_t         cop;
	xes_entry_t       entry;
	logic             fiqN, copOffer, execNop, stallCore, storeToLoad, suppressWrite;
	logic             entryValid, mHi, mLo;
	logic [PSW_W-1:0] link, psw;
	int               num_errors = 0, total_checks = 0, cycles = 0, stalls = 0, lat = 0;
	always #5 clk = ~clk;
	xes_entry_sequencer xes_entry_sequencer_i (.clk, .rst_n, .init_hold_input(hold),
		.fast_interrupt_request_n(fiqN), .normal_interrupt_request_n(irqN),
		.memory_fault_input(fault), .busPhase1End(ph1), .busInternal(intl), .busIsFetch(1'b0),
		.pipeFlush(1'b0), .core, .pc_status_word(pcw), .cop, .copOffer, .execNop, .stallCore,
		.storeToLoad, .suppressWrite, .entryValid, .entry, .link_register(link),
		.processor_status_word(psw), .mode_select_upper(mHi), .mode_select_lower(mLo));
	xes_far_model xes_far_model_i (.clk, .rst_n, .copPresent, .fiqRaise, .copOffer,
		.modeNow({mHi, mLo}), .cop, .fast_interrupt_request_n(fiqN));
	// ----------------
	// tasks
	// ----------------
	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		total_checks++;
		if (got !== exp) begin
			num_errors++;
			$display("unexpected %s: expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic tally_and_finish();
		$display("checks %0d mismatches %0d", total_checks, num_errors);
		if (num_errors == 0 && total_checks > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	function automatic xes_core_t mk(input logic [4:0] f, input logic [31:0] a);
		return {1'b1, f, a};
	endfunction
	// wait for the next entry and check it against the vector table
	task automatic await(input logic [25:0] v, input logic withLink);
		int n;
		logic [31:0] off;
		n = 0;
		off = (v == VEC_DABT) ? 32'h8 : (v >= VEC_PABT) ? 32'h4 : 32'h0;
		while (entryValid !== 1'b1 && n < 40) begin
			@(negedge clk);
			n++;
		end
		chk("entry vector", {5'h0, 1'b1, v}, {5'h0, entryValid, entry.vector});
		chk("mode", {30'h0, (v == VEC_FIQ) ? MODE_FIQ : (v == VEC_IRQ) ? MODE_IRQ : MODE_SVC},
			{30'h0, mHi, mLo});
		chk("disable flags", {30'h0, 1'b1, v == VEC_FIQ || v == VEC_RESET},
			{30'h0, psw[27:26]});
		if (withLink) chk("saved link", pcw + off, link);
		@(negedge clk);
	endtask
	// retire one instruction, held while the block stalls
	task automatic run(input xes_core_t c);
		@(posedge clk);
		core <= c;
		stalls = 0;
		@(negedge clk);
		while (stallCore !== 1'b0 && stalls < 40) begin
			@(negedge clk);
			stalls++;
		end
		@(posedge clk);
		core <= '0;
		@(negedge clk);
	endtask
	// data cycle with the fault pin high; the instruction is shown but not retired yet
	task automatic bus_fault(input logic inner, input xes_core_t c);
		xes_core_t q;
		q = c;
		q.insEnd = 1'b0;
		@(posedge clk);
		core <= q;
		fault <= 1'b1;
		intl <= inner;
		repeat (3) @(posedge clk);
		ph1 <= 1'b1;
		@(posedge clk);
		ph1 <= 1'b0;
		fault <= 1'b0;
		intl <= 1'b0;
		@(negedge clk);
	endtask
	always @(posedge clk) begin
		cycles <= cycles + 1;
		if (cycles == 4000) begin
			num_errors++;
			tally_and_finish();
		end
	end
	// ----------------
	// tests
	// ----------------
	initial begin
		repeat (16) @(posedge clk);
		rst_n <= 1'b1;
		await(VEC_RESET, 1'b0);
		run(mk(5'h08, 32'h0));
		chk("stall cycles", 32'h3, stalls);
		chk("entry after accept", 32'h0, {31'h0, entryValid});
		copPresent <= 1'b0;
		run(mk(5'h08, 32'h0));
		await(VEC_UNDEF, 1'b1);
		run(mk(5'h10, 32'h0));
		await(VEC_SWT, 1'b1);
		$display("test traps done");
		run(mk(5'h04, 32'h0));
		await(VEC_PABT, 1'b1);
		for (int i = 0; i < 2; i++) begin
			bus_fault(i[0], '0);
			chk("write held back", {31'h0, !i[0]}, {31'h0, suppressWrite});
			run(mk(i[0] ? 5'h12 : 5'h02, 32'h100));
			await(i[0] ? VEC_SWT : VEC_DABT, 1'b1);
		end
		$display("test aborts done");
		for (int i = 0; i < 3; i++) begin
			if (i != 1) bus_fault(1'b0, mk(5'h13, adr[i]));
			run(mk(5'h13, adr[i]));
			await(i == 1 ? VEC_SWT : VEC_ADDR, 1'b1);
		end
		$display("test address done");
		for (int i = 0; i < 2; i++) begin
			@(posedge clk);
			pcw[BIT_IRQ_DIS] <= i[0];
			irqN <= 1'b0;
			repeat (3) @(posedge clk);
			run(mk(i[0] ? 5'h10 : 5'h00, 32'h0));
			await(i[0] ? VEC_SWT : VEC_IRQ, 1'b1);
			@(posedge clk);
			irqN <= 1'b1;
			pcw[BIT_IRQ_DIS] <= 1'b0;
		end
		$display("test irq done");
		@(posedge clk);
		fiqRaise <= 1'b1;
		lat = $time;
		@(posedge clk);
		fiqRaise <= 1'b0;
		repeat (3) @(posedge clk);
		run(mk(5'h00, 32'h0));
		await(VEC_FIQ, 1'b1);
		lat = ($time - lat) / 10;
		chk("fast latency", 32'h1, {31'h0, lat >= 3 && lat <= MAX_FIQ_LAT});
		@(posedge clk);
		fiqRaise <= 1'b1;
		@(posedge clk);
		fiqRaise <= 1'b0;
		bus_fault(1'b0, '0);
		run(mk(5'h02, 32'h100));
		await(VEC_DABT, 1'b1);
		await(VEC_FIQ, 1'b0);
		$display("test fast done");
		@(posedge clk);
		hold <= 1'b1;
		repeat (4) @(posedge clk);
		@(negedge clk);
		chk("no-op while held", 32'h1, {31'h0, execNop});
		@(posedge clk);
		hold <= 1'b0;
		await(VEC_RESET, 1'b0);
		$display("test hold done");
		tally_and_finish();
	end
endmodule

// ### sim/xes_far_model.sv
// far-side model: coprocessor answer and fast interrupt source
`timescale 1ns/100ps
module xes_far_model
	import xes_pkg::*;
(
	// clock and reset
	input  logic              clk,
	input  logic              rst_n,
	// bench controls
	input  logic              copPresent,
	input  logic              fiqRaise,
	// block side
	input  logic              copOffer,
	input  logic [1:0]        modeNow,
	output xes_pkg::xes_cop_t cop,
	output logic              fast_interrupt_request_n
);
	localparam logic [3:0] BUSY_LEN = 4'h3;
	logic [3:0] busyCnt_r;
	logic       fiqHeld_r;
	// ----------------
	// answers
	// ----------------
	assign cop.accept = copOffer & copPresent;
	assign cop.busy = cop.accept & (busyCnt_r != 4'h0);
	assign fast_interrupt_request_n = !fiqHeld_r;
	// busy count restarts between offers
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) busyCnt_r <= BUSY_LEN;
		else if (!copOffer) busyCnt_r <= BUSY_LEN;
		else if (cop.busy) busyCnt_r <= busyCnt_r - 4'h1;
	end
	// request held low until the mode shows fast mode
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) fiqHeld_r <= 1'b0;
		else if (fiqRaise) fiqHeld_r <= 1'b1;
		else if (modeNow == MODE_FIQ) fiqHeld_r <= 1'b0;
	end
endmodule
